//--- hdl/mst_pkg.sv
// Shared constants for the microstep translator: register map, field
// layout, resolution codes and the quarter-wave current table.
// Assumes a single sys_clk domain and an AHB-Lite register port.
package mst_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] MST_REG_CTRL   = 8'h00;
	localparam logic [7:0] MST_REG_STATUS = 8'h04;
	localparam logic [7:0] MST_REG_PHASE  = 8'h08;
	localparam int         MST_ADDR_W     = 8;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         MST_CTRL_RES_LO  = 0;
	localparam int         MST_CTRL_RES_HI  = 1;
	localparam logic [1:0] MST_CTRL_RST     = 2'h0;
	localparam int         MST_ST_IDX_LSB   = 0;
	localparam int         MST_ST_RES_LSB   = 6;
	localparam int         MST_ST_DIR       = 8;
	localparam int         MST_PH_A_LSB     = 0;
	localparam int         MST_PH_A_NEG     = 6;
	localparam int         MST_PH_B_LSB     = 8;
	localparam int         MST_PH_B_NEG     = 14;
	localparam logic [5:0] MST_IDX_RST      = 6'h00;
	localparam logic [1:0] MST_HTRANS_NSEQ  = 2'h2;

	// ----------------------------------------------------------------
	// Resolution codes {hi, lo}, step spans and landing offsets
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MST_RES_FULL    = 2'b00,
		MST_RES_HALF    = 2'b01,
		MST_RES_QUARTER = 2'b10,
		MST_RES_SIXTEEN = 2'b11
	} mst_res_t;

	localparam logic [5:0] MST_SPAN_FULL    = 6'h10;
	localparam logic [5:0] MST_SPAN_HALF    = 6'h08;
	localparam logic [5:0] MST_SPAN_QUARTER = 6'h04;
	localparam logic [5:0] MST_SPAN_SIXTEEN = 6'h01;
	localparam logic [5:0] MST_OFS_FULL     = 6'h08;
	localparam logic [5:0] MST_OFS_OTHER    = 6'h00;
	localparam logic [5:0] MST_MAG_FULL     = 6'h3F;

	// Quarter-wave magnitudes, 63*sin(k*5.625 deg), k = 0..16
	localparam logic [5:0] MST_QTR [0:16] = '{
		6'h00, 6'h06, 6'h0C, 6'h12, 6'h18, 6'h1E, 6'h23, 6'h28, 6'h2D,
		6'h31, 6'h34, 6'h38, 6'h3A, 6'h3C, 6'h3E, 6'h3F, 6'h3F
	};

endpackage

//--- hdl/mst_tbl_if.sv
// Carrier between the translator and its phase table memory.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface mst_tbl_if;
	logic [5:0] idx;    // Step angle index to look up
	logic [5:0] a_mag;  // Phase A magnitude
	logic       a_neg;  // Phase A negative
	logic [5:0] b_mag;  // Phase B magnitude
	logic       b_neg;  // Phase B negative

	modport rom  (input idx, output a_mag, a_neg, b_mag, b_neg);
	modport user (output idx, input a_mag, a_neg, b_mag, b_neg);
endinterface
`default_nettype wire

//--- hdl/mst_phase_rom.sv
// Phase current table: 64 signed entries, read data registered.
// Assumes the index is stable from sys_clk logic.
`timescale 1ns/100ps
`default_nettype none
module mst_phase_rom
	import mst_pkg::*;
(
	input  wire logic sys_clk,  // System clock
	input  wire logic arst_n,   // Async reset, active low
	input  wire logic clk_en,   // Freezes state while low
	mst_tbl_if.rom    tbl       // Lookup port
);
	logic [13:0] entry [0:63];
	logic [5:0]  a_mag_q, a_mag_d, b_mag_q, b_mag_d;
	logic        a_neg_q, a_neg_d, b_neg_q, b_neg_d;

	// ----------------------------------------------------------------
	// Entry build: A follows sine, B follows cosine
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 64; i++) begin : g_ent
			localparam int Q = i / 16;
			localparam int K = i % 16;
			localparam logic [5:0] SA = (Q % 2 == 0) ? MST_QTR[K] : MST_QTR[16 - K];
			localparam logic [5:0] SB = (Q % 2 == 0) ? MST_QTR[16 - K] : MST_QTR[K];
			localparam logic       NA = (Q >= 2) && (SA != 6'h00);
			localparam logic       NB = (Q == 1 || Q == 2) && (SB != 6'h00);
			assign entry[i] = {NB, SB, NA, SA};
		end
	endgenerate

	always_comb begin
		a_mag_d = a_mag_q;
		a_neg_d = a_neg_q;
		b_mag_d = b_mag_q;
		b_neg_d = b_neg_q;
		if (clk_en) begin
			{b_neg_d, b_mag_d, a_neg_d, a_mag_d} = entry[tbl.idx];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			a_mag_q <= 6'h00;
			a_neg_q <= 1'b0;
			b_mag_q <= 6'h00;
			b_neg_q <= 1'b0;
		end else begin
			a_mag_q <= a_mag_d;
			a_neg_q <= a_neg_d;
			b_mag_q <= b_mag_d;
			b_neg_q <= b_neg_d;
		end
	end

	assign tbl.a_mag = a_mag_q;
	assign tbl.a_neg = a_neg_q;
	assign tbl.b_mag = b_mag_q;
	assign tbl.b_neg = b_neg_q;

	zero_entry_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && tbl.idx == 6'h00) |=>
		(b_mag_q == MST_MAG_FULL && !b_neg_q && a_mag_q == 6'h00))
		else $error("index zero is not B full positive, A zero");

endmodule
`default_nettype wire

//--- hdl/mst_translator.sv
// Microstep translator: step/direction and serial step-change drive a
// 6-bit step angle index that looks up the phase current table.
// Assumes AHB-Lite single-word transfers, one master, sys_clk 200 MHz.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module mst_translator
	import mst_pkg::*;
(
	input  wire logic        sys_clk,            // System clock, 200 MHz
	input  wire logic        arst_n,             // Async reset, active low
	input  wire logic        clk_en,             // Freezes all state while low
	input  wire logic        step_pin,           // Step input, async
	input  wire logic        dir_pin,            // Direction, high = forward
	input  wire logic        resolution_sel_lo,  // Resolution select low bit
	input  wire logic        resolution_sel_hi,  // Resolution select high bit
	input  wire logic        serial_strobe_n,    // Serial strobe, acts on rise
	input  wire logic [5:0]  step_change_value,  // Signed serial step change
	input  wire logic        hsel,               // AHB select
	input  wire logic [31:0] haddr,              // AHB address
	input  wire logic [1:0]  htrans,             // AHB transfer type
	input  wire logic        hwrite,             // AHB write
	input  wire logic [2:0]  hsize,              // AHB size
	input  wire logic [31:0] hwdata,             // AHB write data
	input  wire logic        hready,             // AHB bus ready
	output logic      [31:0] hrdata,             // AHB read data
	output logic             hreadyout,          // AHB slave ready
	output logic             hresp,              // AHB response, OKAY
	output logic      [5:0]  step_index,         // Step angle index
	output logic      [5:0]  phase_a_mag,        // Phase A level code
	output logic             phase_a_neg,        // Phase A negative
	output logic      [5:0]  phase_b_mag,        // Phase B level code
	output logic             phase_b_neg         // Phase B negative
);
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [10:0] sync1_q, sync1_d, sync2_q, sync2_d;
	logic        step_prev_q, step_prev_d, strb_prev_q, strb_prev_d;
	logic        step_s, dir_s, sel_lo_s, sel_hi_s, strb_s;
	logic [5:0]  sc_s;
	logic        step_rise, strb_rise;

	always_comb begin
		sync1_d     = sync1_q;
		sync2_d     = sync2_q;
		step_prev_d = step_prev_q;
		strb_prev_d = strb_prev_q;
		if (clk_en) begin
			sync1_d     = {step_change_value, serial_strobe_n, resolution_sel_hi,
			               resolution_sel_lo, dir_pin, step_pin};
			sync2_d     = sync1_q;
			step_prev_d = step_s;
			strb_prev_d = strb_s;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q     <= 11'h010;
			sync2_q     <= 11'h010;
			step_prev_q <= 1'b0;
			strb_prev_q <= 1'b1;
		end else begin
			sync1_q     <= sync1_d;
			sync2_q     <= sync2_d;
			step_prev_q <= step_prev_d;
			strb_prev_q <= strb_prev_d;
		end
	end

	assign {sc_s, strb_s, sel_hi_s, sel_lo_s, dir_s, step_s} = sync2_q;
	assign step_rise = clk_en && step_s && !step_prev_q;
	assign strb_rise = clk_en && strb_s && !strb_prev_q;

	// ----------------------------------------------------------------
	// Resolution and index
	// ----------------------------------------------------------------
	logic [1:0] res_reg_q, res_reg_d;
	logic [5:0] idx_q, idx_d, span, ofs, after_step;
	mst_res_t   res_eff;

	// Pin OR register, sampled at the edge that uses it
	assign res_eff = mst_res_t'({sel_hi_s | res_reg_q[1], sel_lo_s | res_reg_q[0]});

	always_comb begin
		case (res_eff)
			MST_RES_FULL: begin
				span = MST_SPAN_FULL;
				ofs  = MST_OFS_FULL;
			end
			MST_RES_HALF: begin
				span = MST_SPAN_HALF;
				ofs  = MST_OFS_OTHER;
			end
			MST_RES_QUARTER: begin
				span = MST_SPAN_QUARTER;
				ofs  = MST_OFS_OTHER;
			end
			default: begin
				span = MST_SPAN_SIXTEEN;
				ofs  = MST_OFS_OTHER;
			end
		endcase
	end

	// Nearest allowed index strictly past the current one; 6-bit wrap
	always_comb begin
		if (dir_s) begin
			after_step = ((idx_q - ofs + span) & ~(span - 6'h01)) + ofs;
		end else begin
			after_step = ((idx_q - ofs - 6'h01) & ~(span - 6'h01)) + ofs;
		end
	end

	always_comb begin
		idx_d = idx_q;
		if (step_rise) begin
			idx_d = after_step;
		end
		// Both in one cycle: both are applied, serial change last
		if (strb_rise) begin
			idx_d = idx_d + sc_s;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	logic [MST_ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic                  wr_pend_q, wr_pend_d;
	logic [31:0]           rdata_q, rdata_d;
	logic                  take;
	mst_tbl_if             tbl ();

	assign take = hsel && hready && htrans[1];

	always_comb begin
		wr_addr_d = wr_addr_q;
		wr_pend_d = wr_pend_q;
		rdata_d   = rdata_q;
		res_reg_d = res_reg_q;
		if (clk_en) begin
			if (wr_pend_q && wr_addr_q == MST_REG_CTRL) begin
				res_reg_d = {hwdata[MST_CTRL_RES_HI], hwdata[MST_CTRL_RES_LO]};
			end
			wr_pend_d = take && hwrite;
			if (take) begin
				wr_addr_d = haddr[MST_ADDR_W-1:0];
			end
			rdata_d = 32'h0000_0000;
			if (take && !hwrite) begin
				case (haddr[MST_ADDR_W-1:0])
					MST_REG_CTRL:   rdata_d[1:0] = res_reg_q;
					MST_REG_STATUS: rdata_d[8:0] = {dir_s, res_eff, idx_q};
					MST_REG_PHASE:  rdata_d[14:0] = {tbl.b_neg, tbl.b_mag, 1'b0,
					                                 tbl.a_neg, tbl.a_mag};
					default:        rdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			res_reg_q <= MST_CTRL_RST;
			idx_q     <= MST_IDX_RST;
			wr_addr_q <= 8'h00;
			wr_pend_q <= 1'b0;
			rdata_q   <= 32'h0000_0000;
		end else begin
			res_reg_q <= res_reg_d;
			idx_q     <= idx_d;
			wr_addr_q <= wr_addr_d;
			wr_pend_q <= wr_pend_d;
			rdata_q   <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Phase table and outputs
	// ----------------------------------------------------------------
	assign tbl.idx = idx_q;

	mst_phase_rom u_rom (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.tbl     (tbl)
	);

	// Ready and OKAY each in a flop, so no output passes a gate
	logic one_q, zero_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			one_q  <= 1'b1;
			zero_q <= 1'b0;
		end else begin
			one_q  <= 1'b1;
			zero_q <= 1'b0;
		end
	end

	assign hrdata      = rdata_q;
	assign hreadyout   = one_q;
	assign hresp       = zero_q;
	assign step_index  = idx_q;
	assign phase_a_mag = tbl.a_mag;
	assign phase_a_neg = tbl.a_neg;
	assign phase_b_mag = tbl.b_mag;
	assign phase_b_neg = tbl.b_neg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	full_land_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(step_rise && !strb_rise && res_eff == MST_RES_FULL) |=> idx_q[3:0] == 4'h8)
		else $error("full step landed off a 45 degree index");
	half_land_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(step_rise && !strb_rise && res_eff == MST_RES_HALF) |=> idx_q[2:0] == 3'h0)
		else $error("half step landed off a multiple of eight");
	quarter_land_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(step_rise && !strb_rise && res_eff == MST_RES_QUARTER) |=> idx_q[1:0] == 2'h0)
		else $error("quarter step landed off a multiple of four");
	fine_fwd_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(step_rise && !strb_rise && res_eff == MST_RES_SIXTEEN && dir_s)
		|=> idx_q == 6'($past(idx_q) + 6'h01))
		else $error("forward sixteenth step did not add one");
	fine_rev_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(step_rise && !strb_rise && res_eff == MST_RES_SIXTEEN && !dir_s)
		|=> idx_q == 6'($past(idx_q) - 6'h01))
		else $error("reverse sixteenth step did not subtract one");
	serial_add_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(strb_rise && !step_rise) |=> idx_q == 6'($past(idx_q) + $past(sc_s)))
		else $error("serial strobe did not add the step change");
	idx_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(!step_rise && !strb_rise) |=> $stable(idx_q))
		else $error("index moved without an edge");
	edge_once_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(step_rise && !strb_rise) |=> (!step_rise && idx_q != $past(idx_q)))
		else $error("one step edge did not move the index exactly once");
	res_or_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(res_reg_q == 2'h0 && clk_en) |-> (res_eff == mst_res_t'({sel_hi_s, sel_lo_s})))
		else $error("cleared register does not leave pins in control");

endmodule
`default_nettype wire

//--- tb/mst_host_model.sv
// Host controller model: drives step, direction, resolution select
// and the serial step-change strobe. Runs on the bench's sys_clk.
`timescale 1ns/100ps
`default_nettype none
module mst_host_model (
	input  wire logic       sys_clk,            // Bench clock
	output logic            step_pin,           // Step output
	output logic            dir_pin,            // Direction, high forward
	output logic            resolution_sel_lo,  // Select low bit
	output logic            resolution_sel_hi,  // Select high bit
	output logic            serial_strobe_n,    // Serial strobe
	output logic      [5:0] step_change_value   // Signed step change
);
	initial begin
		step_pin = 1'b0;
		dir_pin = 1'b0;
		{resolution_sel_hi, resolution_sel_lo} = 2'h0;
		serial_strobe_n = 1'b1;
		step_change_value = 6'h00;
	end

	// ------------------------------------------------------------
	// Step pulse: select and direction settle three clocks first
	// ------------------------------------------------------------
	task automatic step(input logic d, input logic [1:0] r);
		@(posedge sys_clk);
		dir_pin <= d;
		{resolution_sel_hi, resolution_sel_lo} <= r;
		repeat (3) @(posedge sys_clk);
		step_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		step_pin <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	// ------------------------------------------------------------
	// Serial step change; value scrambled once it has been taken
	// ------------------------------------------------------------
	task automatic serial(input logic [5:0] v);
		@(posedge sys_clk);
		step_change_value <= v;
		serial_strobe_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		serial_strobe_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		step_change_value <= ~v;
		repeat (3) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

//--- tb/tb_microstep_translator.sv
// Self-checking bench for the translator: AHB-Lite master tasks plus
// a host model; expectations come from a table walk of the index.
`timescale 1ns/100ps
`default_nettype none
module tb_microstep_translator;
	import mst_pkg::*;

	typedef struct packed {
		logic       ser;
		logic       dir;
		logic [1:0] pins;
		logic [1:0] ctl;
		logic [5:0] val;
	} mst_op_t;

	logic        sys_clk, arst_n, clk_en, hsel, hwrite, hresp, hreadyout;
	logic        step_pin, dir_pin, sel_lo, sel_hi, strobe_n;
	logic [5:0]  chg, step_index, a_mag, b_mag;
	logic        a_neg, b_neg;
	logic [1:0]  htrans, ctl, pins;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [5:0]  idx;
	logic        dir;
	int          err_count, tests_run, n;
	mst_op_t     op;
	mst_op_t     ops [20] = '{
		'{1'b0, 1'b1, 2'h3, 2'h0, 6'h00}, // 1
		'{1'b0, 1'b0, 2'h3, 2'h0, 6'h00}, // 0
		'{1'b0, 1'b0, 2'h3, 2'h0, 6'h00}, // 63
		'{1'b1, 1'b0, 2'h3, 2'h0, 6'h3C}, // 59
		'{1'b0, 1'b1, 2'h2, 2'h0, 6'h00}, // 60
		'{1'b1, 1'b1, 2'h2, 2'h0, 6'h3F}, // 59
		'{1'b0, 1'b1, 2'h1, 2'h0, 6'h00}, // 0
		'{1'b1, 1'b1, 2'h1, 2'h0, 6'h3B}, // 59
		'{1'b0, 1'b1, 2'h0, 2'h0, 6'h00}, // 8
		'{1'b0, 1'b1, 2'h0, 2'h0, 6'h00}, // 24
		'{1'b0, 1'b0, 2'h0, 2'h0, 6'h00}, // 8
		'{1'b0, 1'b0, 2'h0, 2'h0, 6'h00}, // 56
		'{1'b0, 1'b0, 2'h1, 2'h0, 6'h00}, // 48
		'{1'b1, 1'b0, 2'h1, 2'h0, 6'h1F}, // 15
		'{1'b0, 1'b1, 2'h2, 2'h0, 6'h00}, // 16
		'{1'b1, 1'b1, 2'h2, 2'h0, 6'h20}, // 48
		'{1'b0, 1'b0, 2'h0, 2'h3, 6'h00}, // 47
		'{1'b0, 1'b1, 2'h1, 2'h2, 6'h00}, // 48
		'{1'b0, 1'b1, 2'h0, 2'h1, 6'h00}, // 56
		'{1'b0, 1'b1, 2'h0, 2'h0, 6'h00}  // 8
	};

	mst_host_model host (.sys_clk(sys_clk), .step_pin(step_pin), .dir_pin(dir_pin),
		.resolution_sel_lo(sel_lo), .resolution_sel_hi(sel_hi),
		.serial_strobe_n(strobe_n), .step_change_value(chg));

	mst_translator uut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.step_pin(step_pin), .dir_pin(dir_pin), .resolution_sel_lo(sel_lo),
		.resolution_sel_hi(sel_hi), .serial_strobe_n(strobe_n),
		.step_change_value(chg), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.step_index(step_index), .phase_a_mag(a_mag), .phase_a_neg(a_neg),
		.phase_b_mag(b_mag), .phase_b_neg(b_neg));

	// ------------------------------------------------------------
	// Reference model and helpers
	// ------------------------------------------------------------
	function automatic logic [5:0] next_idx(logic [5:0] i, logic [1:0] r, logic d);
		logic [5:0] c;
		for (int k = 1; k <= 64; k++) begin
			c = d ? i + k[5:0] : i - k[5:0];
			if (r == 2'h3 || (r == 2'h2 && c[1:0] == 2'h0) ||
			    (r == 2'h1 && c[2:0] == 3'h0) || (r == 2'h0 && c[3:0] == 4'h8))
				return c;
		end
		return i;
	endfunction

	// Quarter-wave mirror: second and fourth quadrants run backwards
	function automatic logic [5:0] mag(logic [5:0] i);
		int k;
		k = i[3:0];
		return i[4] ? MST_QTR[16 - k] : MST_QTR[k];
	endfunction

	function automatic logic [31:0] phase_word(logic [5:0] i);
		logic [5:0] j;
		j = i + 6'h10;
		return {17'h0, j > 6'h20, mag(j), 1'b0, i > 6'h20, mag(i)};
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= MST_HTRANS_NSEQ;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic check_state();
		chk("index", {26'h0, idx}, {26'h0, step_index});
		ahb(MST_REG_STATUS, 1'b0, 32'h0);
		chk("status", {23'h0, dir, pins | ctl, idx}, rd);
		ahb(MST_REG_PHASE, 1'b0, 32'h0);
		chk("phase reg", phase_word(idx), rd);
		chk("phase out", phase_word(idx), {17'h0, b_neg, b_mag, 1'b0, a_neg, a_mag});
	endtask

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, reset, watchdog, main sequence
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		give_verdict();
	end

	initial begin
		{arst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		clk_en = 1'b1;
		{err_count, tests_run} = '0;
		{ctl, pins, idx, dir} = '0;
		repeat (4) @(posedge sys_clk);
		chk("ready in reset", 32'h1, {31'h0, hreadyout});
		arst_n <= 1'b1;
		ahb(MST_REG_CTRL, 1'b0, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		check_state();
		ahb(8'h0C, 1'b1, 32'hFFFF_FFFF);
		ahb(8'h0C, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		ahb(MST_REG_STATUS, 1'b1, 32'h0000_003F);
		check_state();
		for (n = 0; n < 20; n++) begin
			op = ops[n];
			if (op.ctl !== ctl) begin
				ctl = op.ctl;
				ahb(MST_REG_CTRL, 1'b1, {30'h0, ctl});
				ahb(MST_REG_CTRL, 1'b0, 32'h0);
				chk("ctrl", {30'h0, ctl}, rd);
			end
			if (op.ser) begin
				host.serial(op.val);
				idx = idx + op.val;
			end else begin
				host.step(op.dir, op.pins);
				pins = op.pins;
				dir = op.dir;
				idx = next_idx(idx, pins | ctl, dir);
			end
			check_state();
		end
		// Step pulse while frozen must be lost, not replayed on wake-up
		clk_en <= 1'b0;
		host.step(1'b1, 2'h3);
		chk("frozen index", {26'h0, idx}, {26'h0, step_index});
		clk_en <= 1'b1;
		pins = 2'h3;
		dir = 1'b1;
		repeat (3) @(posedge sys_clk);
		check_state();
		give_verdict();
	end
endmodule
`default_nettype wire
